/* npb_pkg.sv */
// Constants and types of the NAND pin bus host controller.
package npb_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int STROBE_LOW_NS = 25;
    localparam int STROBE_HIGH_NS = 15;
    localparam int READ_VALID_NS = 30;

    function automatic logic [3:0] cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        if (c < 1) begin
            c = 1;
        end
        return c[3:0];
    endfunction

    localparam logic [3:0] SYNC_LAT = 4'h4;
    localparam logic [3:0] LOW_CYC = cyc_up(STROBE_LOW_NS);
    localparam logic [3:0] HIGH_CYC = cyc_up(STROBE_HIGH_NS);
    localparam logic [3:0] READ_LOW_CYC = cyc_up(READ_VALID_NS) + SYNC_LAT;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OP = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0C;
    localparam logic [7:0] OFS_RDATA = 8'h10;

    localparam int CTRL_X16 = 0;
    localparam int CTRL_WP_N = 1;
    localparam int CTRL_LOCK = 2;
    localparam int CTRL_SELECT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    localparam int OP_KIND_LSB = 30;
    localparam int OP_CNT_LSB = 28;
    localparam logic [1:0] KIND_CMD = 2'h0;
    localparam logic [1:0] KIND_ADDR = 2'h1;
    localparam logic [1:0] KIND_WDATA = 2'h2;
    localparam logic [1:0] KIND_RDATA = 2'h3;
    localparam logic [1:0] ERASE_CNT = 2'h2;

    localparam int ROW_LO_LSB = 9;
    localparam int ROW_HI_LSB = 17;

    // Status bits: done, device ready rise, refused.
    localparam int STATUS_W = 3;
    localparam int RD_BUSY = 16;
    localparam int RD_READY = 17;
    localparam int RD_HALF = 18;

    localparam logic [7:0] CMD_READ_LO = 8'h00;
    localparam logic [7:0] CMD_READ_HI = 8'h01;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int SYNC_W = 17;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_LOW = 4'h4,
        ST_HIGH = 4'h8
    } npb_state_t;

endpackage

/* npb_sync_if.sv */
// Interface carrying pin levels into the synchroniser and clean levels back.
`timescale 1ns/10ps
`default_nettype none
interface npb_sync_if;
    logic [npb_pkg::SYNC_W-1:0] raw;
    logic [npb_pkg::SYNC_W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface
`default_nettype wire

/* npb_sync.sv */
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/10ps
`default_nettype none
module npb_sync (
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // Pins in, clean levels out
    npb_sync_if.sync port
);
    localparam logic [npb_pkg::SYNC_W-1:0] RST_VAL = 17'h10000;

    logic [npb_pkg::SYNC_W-1:0] s1;
    logic [npb_pkg::SYNC_W-1:0] s2;
    logic [npb_pkg::SYNC_W-1:0] s3;
    logic [npb_pkg::SYNC_W-1:0] clean;
    wire [npb_pkg::SYNC_W-1:0] agree = ~(s2 ^ s3);
    wire [npb_pkg::SYNC_W-1:0] next_clean = (s3 & agree) | (clean & ~agree);

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            clean <= RST_VAL;
        end else begin
            s1 <= port.raw;
            s2 <= s1;
            s3 <= s2;
            clean <= next_clean;
        end
    end

    assign port.clean = clean;
endmodule
`default_nettype wire

/* npb_host_ctrl.sv */
// Host controller driving a NAND flash pin bus from AXI4-Lite registers.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module npb_host_ctrl (
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Flash pins
    output logic chip_select_n,
    output logic cmd_latch_en,
    output logic addr_latch_en,
    output logic write_strobe_n,
    output logic out_strobe_n,
    output logic write_protect_n,
    output logic lock_autoload_en,
    output logic [15:0] io_out,
    output logic io_oe,
    input wire logic [15:0] io_in,
    input wire logic idle_flag_n,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    npb_sync_if sif ();
    assign sif.raw = {idle_flag_n, io_in};
    npb_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .port(sif.sync)
    );
    wire dev_ready = sif.clean[16];
    wire [15:0] bus_in = sif.clean[15:0];

    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    logic [3:0] ctrl;
    logic [npb_pkg::STATUS_W-1:0] status;
    logic [npb_pkg::STATUS_W-1:0] mask;
    logic [31:0] op;
    npb_pkg::npb_state_t state;
    logic [3:0] cnt;
    logic [1:0] byte_idx;
    logic [15:0] rd_data;
    logic half_sel;
    logic ready_q;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awready && s_axi_awvalid;
    wire wr_ctrl = aw_take && s_axi_awaddr == npb_pkg::OFS_CTRL;
    wire wr_op = aw_take && s_axi_awaddr == npb_pkg::OFS_OP;
    wire wr_stat = aw_take && s_axi_awaddr == npb_pkg::OFS_STATUS;
    wire wr_mask = aw_take && s_axi_awaddr == npb_pkg::OFS_MASK;
    wire wr_hit = wr_ctrl || wr_op || wr_stat || wr_mask;
    wire lane0 = s_axi_wstrb[0];
    wire op_go = wr_op && s_axi_wstrb == 4'hF && state == npb_pkg::ST_IDLE;
    wire refuse = wr_op && !op_go;

    wire [1:0] kind = op[npb_pkg::OP_KIND_LSB +: 2];
    wire [1:0] acnt = op[npb_pkg::OP_CNT_LSB +: 2];
    wire is_cmd = kind == npb_pkg::KIND_CMD;
    wire is_addr = kind == npb_pkg::KIND_ADDR;
    wire is_read = kind == npb_pkg::KIND_RDATA;
    wire skip_col = acnt == npb_pkg::ERASE_CNT;
    wire [1:0] eff_idx = byte_idx + {1'b0, skip_col};
    wire [7:0] addr_byte = (eff_idx == 2'h0) ? op[7:0] :
        (eff_idx == 2'h1) ? op[npb_pkg::ROW_LO_LSB +: 8] :
        op[npb_pkg::ROW_HI_LSB +: 8];
    wire last_byte = !is_addr || acnt == 2'h0 || byte_idx == acnt - 2'h1;
    wire [15:0] drive_word = is_cmd ? {8'h00, op[7:0]} :
        is_addr ? {8'h00, addr_byte} :
        ctrl[npb_pkg::CTRL_X16] ? op[15:0] : {8'h00, op[7:0]};
    wire cycle_end = state == npb_pkg::ST_HIGH && cnt == 4'h1;
    wire done_ev = cycle_end && last_byte;
    wire ready_rise = dev_ready && !ready_q;
    wire [npb_pkg::STATUS_W-1:0] ev_set = {refuse, ready_rise, done_ev};
    wire [npb_pkg::STATUS_W-1:0] stat_clr =
        (wr_stat && lane0) ? s_axi_wdata[npb_pkg::STATUS_W-1:0] : 3'h0;
    wire [npb_pkg::STATUS_W-1:0] next_status = (status & ~stat_clr) | ev_set;
    wire next_cs_n = !(ctrl[npb_pkg::CTRL_SELECT] ||
        state != npb_pkg::ST_IDLE || !dev_ready);
    wire [31:0] rd_word =
        (s_axi_araddr == npb_pkg::OFS_CTRL) ? {28'h0, ctrl} :
        (s_axi_araddr == npb_pkg::OFS_OP) ? op :
        (s_axi_araddr == npb_pkg::OFS_STATUS) ? {29'h0, status} :
        (s_axi_araddr == npb_pkg::OFS_MASK) ? {29'h0, mask} :
        {13'h0, half_sel, dev_ready, state != npb_pkg::ST_IDLE, rd_data};
    wire rd_hit = s_axi_araddr == npb_pkg::OFS_CTRL ||
        s_axi_araddr == npb_pkg::OFS_OP ||
        s_axi_araddr == npb_pkg::OFS_STATUS ||
        s_axi_araddr == npb_pkg::OFS_MASK ||
        s_axi_araddr == npb_pkg::OFS_RDATA;

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= npb_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid &&
                !s_axi_bvalid && !s_axi_awready;
            s_axi_wready <= s_axi_awvalid && s_axi_wvalid &&
                !s_axi_bvalid && !s_axi_awready;
            if (aw_take) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? npb_pkg::RESP_OKAY :
                    npb_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= npb_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_word : 32'h0;
                s_axi_rresp <= rd_hit ? npb_pkg::RESP_OKAY :
                    npb_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control, status and level pins
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= npb_pkg::CTRL_RESET;
            mask <= 3'h0;
            status <= 3'h0;
            ready_q <= 1'b1;
            irq <= 1'b0;
            chip_select_n <= 1'b1;
            write_protect_n <= 1'b0;
            lock_autoload_en <= 1'b0;
        end else begin
            if (wr_ctrl && lane0) begin
                ctrl <= s_axi_wdata[3:0];
            end
            if (wr_mask && lane0) begin
                mask <= s_axi_wdata[npb_pkg::STATUS_W-1:0];
            end
            status <= next_status;
            ready_q <= dev_ready;
            irq <= |(next_status & mask);
            chip_select_n <= next_cs_n;
            write_protect_n <= ctrl[npb_pkg::CTRL_WP_N];
            lock_autoload_en <= ctrl[npb_pkg::CTRL_LOCK];
        end
    end

    // ------------------------------------------------------------------
    // Pin cycle sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= npb_pkg::ST_IDLE;
            op <= 32'h0;
            cnt <= 4'h0;
            byte_idx <= 2'h0;
            cmd_latch_en <= 1'b0;
            addr_latch_en <= 1'b0;
            write_strobe_n <= 1'b1;
            out_strobe_n <= 1'b1;
            io_out <= 16'h0;
            io_oe <= 1'b0;
            rd_data <= 16'h0;
            half_sel <= 1'b0;
        end else begin
            case (state)
                npb_pkg::ST_IDLE: begin
                    if (op_go) begin
                        op <= s_axi_wdata;
                        byte_idx <= 2'h0;
                        state <= npb_pkg::ST_SETUP;
                    end
                end
                npb_pkg::ST_SETUP: begin
                    cmd_latch_en <= is_cmd;
                    addr_latch_en <= is_addr;
                    io_out <= drive_word;
                    io_oe <= !is_read;
                    cnt <= (is_read ? npb_pkg::READ_LOW_CYC :
                        npb_pkg::LOW_CYC) + 4'h1;
                    if (is_cmd && !ctrl[npb_pkg::CTRL_X16]) begin
                        if (op[7:0] == npb_pkg::CMD_READ_LO) begin
                            half_sel <= 1'b0;
                        end else if (op[7:0] == npb_pkg::CMD_READ_HI) begin
                            half_sel <= 1'b1;
                        end
                    end
                    state <= npb_pkg::ST_LOW;
                end
                npb_pkg::ST_LOW: begin
                    if (cnt == 4'h1) begin
                        write_strobe_n <= 1'b1;
                        out_strobe_n <= 1'b1;
                        if (is_read) begin
                            rd_data <= bus_in;
                        end
                        cnt <= npb_pkg::HIGH_CYC;
                        state <= npb_pkg::ST_HIGH;
                    end else begin
                        write_strobe_n <= is_read;
                        out_strobe_n <= !is_read;
                        cnt <= cnt - 4'h1;
                    end
                end
                npb_pkg::ST_HIGH: begin
                    if (cnt != 4'h1) begin
                        cnt <= cnt - 4'h1;
                    end else if (last_byte) begin
                        cmd_latch_en <= 1'b0;
                        addr_latch_en <= 1'b0;
                        io_oe <= 1'b0;
                        state <= npb_pkg::ST_IDLE;
                    end else begin
                        byte_idx <= byte_idx + 2'h1;
                        state <= npb_pkg::ST_SETUP;
                    end
                end
                default: begin
                    state <= npb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [1:0] ale_pulses;
    always_ff @(posedge aclk) begin
        if (!aresetn || op_go) begin
            ale_pulses <= 2'h0;
        end else if (addr_latch_en && !write_strobe_n && cnt == 4'h1) begin
            ale_pulses <= ale_pulses + 2'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_latch_exclusive: assert property (!(cmd_latch_en && addr_latch_en))
        else $error("Both latch enables high.");
    chk_upper_lane_low: assert property (
        io_oe && (cmd_latch_en || addr_latch_en) |-> io_out[15:8] == 8'h00)
        else $error("Upper lane not low in command or address cycle.");
    chk_strobe_selected: assert property (
        !write_strobe_n || !out_strobe_n |-> !chip_select_n)
        else $error("Strobe while deselected.");
    chk_cmd_held_rise: assert property (
        $rose(write_strobe_n) && $past(cmd_latch_en) |-> cmd_latch_en)
        else $error("Command latch dropped before strobe rise.");
    chk_addr_held_rise: assert property (
        $rose(write_strobe_n) && $past(addr_latch_en) |-> addr_latch_en)
        else $error("Address latch dropped before strobe rise.");
    chk_strobe_low_len: assert property (
        $fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
        else $error("Write strobe low time wrong.");
    chk_read_bus_free: assert property (!out_strobe_n |-> !io_oe)
        else $error("Host drives bus during read.");
    chk_busy_selected: assert property (!dev_ready |=> !chip_select_n)
        else $error("Chip select raised while device busy.");
    chk_addr_count: assert property (
        done_ev && is_addr && acnt != 2'h0 |=> ale_pulses == $past(acnt))
        else $error("Wrong number of address cycles.");
    chk_wp_follows: assert property (
        wr_ctrl && lane0 |-> ##2 write_protect_n == $past(s_axi_wdata[1], 2))
        else $error("Write protect pin does not follow control.");

    cov_cmd_cycle: cover property ($rose(write_strobe_n) && cmd_latch_en);
    cov_three_addr: cover property (done_ev && is_addr && acnt == 2'h3);
    cov_read_word: cover property ($rose(out_strobe_n));
    cov_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

/* npb_flash_model.sv */
// Behavioural flash device that answers the host controller's pins.
`timescale 1ns/10ps
`default_nettype none
module npb_flash_model #(
    parameter int BUSY_NS = 2000,
    parameter bit TOP_SUPPLY = 1'h1
) (
    // Pins from the host
    input wire logic chip_select_n,
    input wire logic cmd_latch_en,
    input wire logic addr_latch_en,
    input wire logic write_strobe_n,
    input wire logic out_strobe_n,
    input wire logic write_protect_n,
    input wire logic lock_autoload_en,
    input wire logic [15:0] io,
    input wire logic wide,
    // Pins to the host
    output logic [15:0] dout,
    output logic dout_oe,
    output logic pull_low
);
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] abyte [0:2];
    logic [1:0] n_addr = 2'h0;
    logic [8:0] col = 9'h000;
    logic half_select_bit = 1'h0;
    logic [15:0] page [0:511];
    logic busy = 1'h0;
    logic locked = 1'h0;
    logic hi_lane_dirty = 1'h0;
    logic auto_read_en;

    assign dout_oe = !chip_select_n && !out_strobe_n;
    assign pull_low = busy;
    assign auto_read_en = lock_autoload_en && TOP_SUPPLY;

    always @(posedge write_strobe_n) begin
        if (!chip_select_n) begin
            if (cmd_latch_en) begin
                cmd_reg = io[7:0];
                n_addr = 2'h0;
                if (!wide && io[7:1] == 7'h00) begin
                    half_select_bit = io[0];
                end
                if (write_protect_n && (io[7:0] == 8'h10 || io[7:0] == 8'hD0)) begin
                    busy = 1'h1;
                end
            end else if (addr_latch_en) begin
                if (io[15:8] != 8'h00) begin
                    hi_lane_dirty = 1'h1;
                end
                if (n_addr < 2'h3) begin
                    abyte[n_addr] = io[7:0];
                    if (n_addr == 2'h0) begin
                        col = {half_select_bit & !wide, io[7:0]};
                    end
                    n_addr = n_addr + 2'h1;
                end
            end else begin
                page[col] = wide ? io : {8'h00, io[7:0]};
                col = col + 9'h001;
            end
        end
    end

    // Busy ends on its own; deselecting does not shorten it.
    always @(posedge busy) begin
        #(BUSY_NS);
        busy = 1'h0;
    end

    always @(negedge out_strobe_n) begin
        if (!chip_select_n) begin
            dout = page[col];
            col = col + 9'h001;
        end
    end

    always @(lock_autoload_en or write_protect_n) begin
        if (lock_autoload_en && !write_protect_n) begin
            locked = 1'h1;
        end
    end
endmodule
`default_nettype wire

/* npb_tb.sv */
// Self-checking bench for the flash pin bus host controller.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cs_n, cle, ale, we_n, re_n, wp_n, lk_en, io_oe, irq, dev_oe;
    logic pull_low, idle_n, m_done;
    logic wide = 1'h0;
    logic [15:0] io_out, io_bus, dev_do;
    logic [15:0] io_hold = 16'h0;
    int n_fail = 0;
    int samples_checked = 0;

    always #2.5 aclk = ~aclk;
    assign idle_n = pull_low ? 1'h0 : 1'h1;
    assign io_bus = io_oe ? io_out : (dev_oe ? dev_do : ~io_hold);
    always @(io_oe or io_out or dev_oe or dev_do) begin
        if (io_oe === 1'h1) io_hold = io_out;
        else if (dev_oe === 1'h1) io_hold = dev_do;
    end

    npb_host_ctrl dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chip_select_n(cs_n),
        .cmd_latch_en(cle), .addr_latch_en(ale), .write_strobe_n(we_n),
        .out_strobe_n(re_n), .write_protect_n(wp_n), .lock_autoload_en(lk_en),
        .io_out(io_out), .io_oe(io_oe), .io_in(io_bus), .idle_flag_n(idle_n),
        .irq(irq));
    npb_flash_model flash (.chip_select_n(cs_n), .cmd_latch_en(cle),
        .addr_latch_en(ale), .write_strobe_n(we_n), .out_strobe_n(re_n),
        .write_protect_n(wp_n), .lock_autoload_en(lk_en), .io(io_bus),
        .wide(wide), .dout(dev_do), .dout_oe(dev_oe), .pull_low(pull_low));

    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awready === 1'h1) begin
                awvalid <= 1'h0;
                aw_ok = 1'h1;
            end
            if (wready === 1'h1) begin
                wvalid <= 1'h0;
                w_ok = 1'h1;
            end
        end
        while (bvalid !== 1'h1) @(posedge aclk);
        bready <= 1'h0;
        chk("write response", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(posedge aclk); while (arready !== 1'h1);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge aclk);
        rready <= 1'h0;
        d = rdata;
        chk("read response", {30'h0, rresp}, {30'h0, er});
    endtask

    task automatic wait_done();
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 60 && s[0] !== 1'h1; i++) begin
            rd(npb_pkg::OFS_STATUS, s, 2'h0);
        end
        chk("op done", {31'h0, s[0]}, 32'h1);
        chk("irq raised", {31'h0, irq}, {31'h0, m_done});
        wr(npb_pkg::OFS_STATUS, 32'h1, 2'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    task automatic op(input logic [1:0] k, input logic [1:0] n,
                      input logic [24:0] p);
        wr(npb_pkg::OFS_OP, {k, n, 3'h0, p}, 2'h0);
        wait_done();
    endtask

    task automatic ctrl(input logic [3:0] c, input logic m);
        m_done = m;
        wide = c[0];
        wr(npb_pkg::OFS_CTRL, {28'h0, c}, 2'h0);
        wr(npb_pkg::OFS_MASK, {31'h0, m}, 2'h0);
    endtask

    always @(posedge aclk) begin
        if (io_oe === 1'h1 && dev_oe === 1'h1) chk("bus clash", 32'h1, 32'h0);
    end

    initial begin
        #200000;
        n_fail++;
        final_report();
    end

    initial begin
        logic [31:0] d;
        logic [24:0] a;
        logic [15:0] v [0:1];
        a = 25'h15AC3E7;
        v[0] = 16'h00A5;
        v[1] = 16'h003C;
        repeat (16) @(posedge aclk);
        chk("select at reset", {31'h0, cs_n}, 32'h1);
        chk("protect at reset", {31'h0, wp_n}, 32'h0);
        aresetn <= 1'h1;
        rd(npb_pkg::OFS_CTRL, d, 2'h0);
        chk("ctrl reset", d, 32'h0);
        rd(8'h40, d, 2'h2);
        wr(8'h40, 32'hFFFFFFFF, 2'h2);
        ctrl(4'h2, 1'h1);
        chk("protect pin", {31'h0, wp_n}, 32'h1);
        for (int h = 0; h < 2; h++) begin
            op(npb_pkg::KIND_CMD, 2'h0, 25'(h));
            chk("command", {24'h0, flash.cmd_reg}, 32'(h));
            rd(npb_pkg::OFS_RDATA, d, 2'h0);
            chk("half mirror", {31'h0, d[18]}, 32'(h));
            chk("half select", {31'h0, flash.half_select_bit}, 32'(h));
        end
        op(npb_pkg::KIND_ADDR, 2'h3, a);
        chk("column", {24'h0, flash.abyte[0]}, {24'h0, a[7:0]});
        chk("row low", {24'h0, flash.abyte[1]}, {24'h0, a[16:9]});
        chk("row high", {24'h0, flash.abyte[2]}, {24'h0, a[24:17]});
        op(npb_pkg::KIND_CMD, 2'h0, 25'h60);
        op(npb_pkg::KIND_ADDR, npb_pkg::ERASE_CNT, a);
        chk("erase bytes", {30'h0, flash.n_addr}, 32'h2);
        chk("erase row", {24'h0, flash.abyte[0]}, {24'h0, a[16:9]});
        for (int w = 0; w < 2; w++) begin
            op(npb_pkg::KIND_CMD, 2'h0, 25'h0);
            op(npb_pkg::KIND_ADDR, 2'h1, 25'h10);
            op(npb_pkg::KIND_WDATA, 2'h0, {9'h0, v[0]});
            op(npb_pkg::KIND_WDATA, 2'h0, {9'h0, v[1]});
            chk("page word", {16'h0, flash.page[17]}, {16'h0, v[1]});
            op(npb_pkg::KIND_CMD, 2'h0, 25'h0);
            op(npb_pkg::KIND_ADDR, 2'h1, 25'h10);
            for (int i = 0; i < 2; i++) begin
                op(npb_pkg::KIND_RDATA, 2'h0, 25'h0);
                rd(npb_pkg::OFS_RDATA, d, 2'h0);
                chk("read word", {16'h0, d[15:0]}, {16'h0, v[i]});
                chk("column step", {23'h0, flash.col}, 32'h11 + 32'(i));
            end
            ctrl(4'h3, 1'h1);
            op(npb_pkg::KIND_ADDR, 2'h3, a);
            chk("upper lane", {31'h0, flash.hi_lane_dirty}, 32'h0);
            v[0] = 16'hBEEF;
            v[1] = 16'h5A01;
        end
        wstrb <= 4'h3;
        wr(npb_pkg::OFS_OP, 32'h00000070, 2'h0);
        wstrb <= 4'hF;
        rd(npb_pkg::OFS_RDATA, d, 2'h0);
        chk("partial op idle", {31'h0, d[16]}, 32'h0);
        rd(npb_pkg::OFS_STATUS, d, 2'h0);
        chk("partial op refused", d, 32'h4);
        wr(npb_pkg::OFS_STATUS, 32'h4, 2'h0);
        ctrl(4'h2, 1'h1);
        wr(npb_pkg::OFS_OP, 32'h00000010, 2'h0);
        wr(npb_pkg::OFS_OP, 32'h00000070, 2'h0);
        wait_done();
        chk("program cmd", {24'h0, flash.cmd_reg}, 32'h10);
        chk("busy pin", {31'h0, idle_n}, 32'h0);
        chk("kept selected", {31'h0, cs_n}, 32'h0);
        rd(npb_pkg::OFS_STATUS, d, 2'h0);
        chk("refused", d, 32'h4);
        wr(npb_pkg::OFS_STATUS, 32'h7, 2'h0);
        d = 32'h0;
        for (int i = 0; i < 300 && d[17] !== 1'h1; i++) begin
            rd(npb_pkg::OFS_RDATA, d, 2'h0);
        end
        chk("ready seen", {31'h0, d[17]}, 32'h1);
        rd(npb_pkg::OFS_STATUS, d, 2'h0);
        chk("ready event", d, 32'h2);
        wr(npb_pkg::OFS_STATUS, 32'h7, 2'h0);
        chk("deselected", {31'h0, cs_n}, 32'h1);
        ctrl(4'hA, 1'h1);
        chk("held select", {31'h0, cs_n}, 32'h0);
        ctrl(4'h0, 1'h0);
        op(npb_pkg::KIND_CMD, 2'h0, 25'h10);
        chk("protected", {31'h0, flash.busy}, 32'h0);
        ctrl(4'h4, 1'h1);
        chk("lock pin", {31'h0, lk_en}, 32'h1);
        chk("all locked", {31'h0, flash.locked}, 32'h1);
        chk("auto read", {31'h0, flash.auto_read_en}, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
